// ==== include/lssl_consts.svh ====
// Constants of the LED sink shift and latch block.
`ifndef LSSL_CONSTS_SVH
`define LSSL_CONSTS_SVH

// ----------------------------------------
// Structure
// ----------------------------------------
`define LSSL_CHANNELS        16
`define LSSL_BUF_DEPTH       2
`define LSSL_SYNC_STAGES     2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LSSL_SHIFT_RESET     16'h0000
`define LSSL_LATCH_RESET     16'h0000
`define LSSL_SINKS_RESET     16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define LSSL_SYS_CLK_MHZ     25
`define LSSL_SCLK_MAX_MHZ    30
`define LSSL_SCLK_PULSE_NS   15
`define LSSL_SCLK_PULSE_CYC  ((`LSSL_SCLK_PULSE_NS * `LSSL_SYS_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// Thermal protection
// ----------------------------------------
`define LSSL_SHUTDOWN_TEMP_C 175
`define LSSL_RESTART_HYST_C  15
`define LSSL_RESTART_TEMP_C  (`LSSL_SHUTDOWN_TEMP_C - `LSSL_RESTART_HYST_C)

`endif

// ==== include/lssl_pkg.sv ====
// Types of the LED sink shift and latch block.
package lssl_pkg;

	// ----------------------------------------
	// Serial bit carried through the buffer
	// ----------------------------------------
	typedef struct packed {
		logic data;
	} lssl_bit_type;

	// ----------------------------------------
	// Synchronised pin levels
	// ----------------------------------------
	typedef struct packed {
		logic serialClk;
		logic serialIn;
		logic latchStrobe;
		logic blank;
		logic overTemp;
		logic coolDown;
	} lssl_pins_type;

	// ----------------------------------------
	// Thermal protection states
	// ----------------------------------------
	typedef enum logic [0:0] {
		LSSL_THERM_RUN = 1'b0,
		LSSL_THERM_OFF = 1'b1
	} lssl_therm_type;

endpackage

// ==== rtl/lssl_buffer.sv ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module lssl_buffer #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// Filling side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    writePtr;
	logic [PW-1:0]    readPtr;
	logic [PW:0]      count;
	logic             doPush;
	logic             doPop;

	// The fill level is one bit wider than the pointers, so full is compared at that width.
	assign inReady  = (count != (PW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData  = store[readPtr];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (doPush) begin
			store[writePtr] <= inData;
		end
	end

	// ----------------------------------------
	// Pointers and fill level
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			writePtr <= '0;
			readPtr  <= '0;
			count    <= '0;
		end else begin
			if (doPush) begin
				writePtr <= (writePtr == PW'(DEPTH - 1)) ? '0 : writePtr + PW'(1);
			end
			if (doPop) begin
				readPtr <= (readPtr == PW'(DEPTH - 1)) ? '0 : readPtr + PW'(1);
			end
			if (doPush && !doPop) begin
				count <= count + (PW+1)'(1);
			end else if (doPop && !doPush) begin
				count <= count - (PW+1)'(1);
			end
		end
	end

endmodule
`default_nettype wire

// ==== rtl/lssl_top.sv ====
// Shift register, output latch and channel gating of the LED sink driver.
//
// Overview of operation
// - Sixteen shift stages and sixteen output latches.
// - Rising serial clock shifts; falling does nothing.
// - Serial output shows the last stage.
// - Newest bit channel 0, oldest channel 15.
// - Strobe high: latches follow shift register.
// - Strobe low: latches hold their value.
// - Blanking low: channels follow latched bits.
// - Blanking high: all channels off, data kept.
// - Undriven strobe reads low.
// - Undriven blanking reads high.
// - Overheat forces off until hysteresis cooled.
`include "lssl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lssl_top (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        reset,
	// Serial pins
	input  wire logic                        serialClk,
	input  wire logic                        serial_in,
	output logic                             serial_out,
	// Strobe pin with its driven flag
	input  wire logic                        latch_strobe,
	input  wire logic                        latchStrobeDriven,
	// Active-high blanking pin with its driven flag
	input  wire logic                        blankN,
	input  wire logic                        blankNDriven,
	// Temperature comparators
	input  wire logic                        overTemp,
	input  wire logic                        coolDown,
	// Buffer control and status
	input  wire logic                        shiftHold,
	output logic                             bitReady,
	output logic                             bitDropped,
	// Channel controls
	output logic [`LSSL_CHANNELS-1:0]        channel_sinks,
	output logic                             thermalOff
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	lssl_pkg::lssl_pins_type   rawPins;
	lssl_pkg::lssl_pins_type   syncFirst;
	lssl_pkg::lssl_pins_type   syncPins;
	lssl_pkg::lssl_bit_type    pushBit;
	lssl_pkg::lssl_bit_type    popBit;
	lssl_pkg::lssl_therm_type  thermState;
	lssl_pkg::lssl_therm_type  next_thermState;
	logic                      prevSerialClk;
	logic                      prevStrobe;
	logic                      clkRise;
	logic                      strobeFall;
	logic                      popValid;
	logic                      popReady;
	logic                      doShift;
	logic [`LSSL_CHANNELS-1:0] shiftReg;
	logic [`LSSL_CHANNELS-1:0] latchReg;
	logic [`LSSL_CHANNELS-1:0] next_sinks;

	function automatic logic risingEdge(input logic prev, input logic cur);
		risingEdge = !prev && cur;
	endfunction

	// ----------------------------------------
	// Pad resolution
	// ----------------------------------------
	always_comb begin
		rawPins.serialClk   = serialClk;
		rawPins.serialIn    = serial_in;
		rawPins.latchStrobe = latchStrobeDriven ? latch_strobe : 1'b0;
		rawPins.blank       = blankNDriven ? blankN : 1'b1;
		rawPins.overTemp    = overTemp;
		rawPins.coolDown    = coolDown;
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Data and clock share the same two-stage path, so the host must hold
	// serial data for a full system cycle around its clock edge.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			syncFirst <= '0;
			syncPins  <= '0;
		end else begin
			syncFirst <= rawPins;
			syncPins  <= syncFirst;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prevSerialClk <= 1'b0;
			prevStrobe    <= 1'b0;
		end else begin
			prevSerialClk <= syncPins.serialClk;
			prevStrobe    <= syncPins.latchStrobe;
		end
	end

	// Only rising edges of the serial clock are taken.
	assign clkRise    = risingEdge(prevSerialClk, syncPins.serialClk);
	assign strobeFall = risingEdge(syncPins.latchStrobe, prevStrobe);

	// ----------------------------------------
	// Bit buffer
	// ----------------------------------------
	// A held shifter would otherwise lose bits; two entries cover a short
	// hold, and a longer one is reported as a dropped bit.
	assign pushBit.data = syncPins.serialIn;
	assign popReady     = !shiftHold;
	assign doShift      = popValid && popReady;

	lssl_buffer #(
		.WIDTH ($bits(lssl_pkg::lssl_bit_type)),
		.DEPTH (`LSSL_BUF_DEPTH)
	) bitBuffer (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.inValid  (clkRise),
		.inReady  (bitReady),
		.inData   (pushBit),
		.outValid (popValid),
		.outReady (popReady),
		.outData  (popBit)
	);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bitDropped <= 1'b0;
		end else if (clkRise && !bitReady) begin
			bitDropped <= 1'b1;
		end
	end

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	// Cleared by reset although contents are undefined at power-up.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			shiftReg <= `LSSL_SHIFT_RESET;
		end else if (doShift) begin
			shiftReg <= {shiftReg[`LSSL_CHANNELS-2:0], popBit.data};
		end
	end

	// Last stage drives the serial output.
	assign serial_out = shiftReg[`LSSL_CHANNELS-1];

	// ----------------------------------------
	// Output latch
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			latchReg <= `LSSL_LATCH_RESET;
		end else if (syncPins.latchStrobe) begin
			latchReg <= shiftReg;
		end
	end
	// Hold happens by not loading while the strobe is low.

	// ----------------------------------------
	// Thermal protection
	// ----------------------------------------
	always_comb begin
		next_thermState = thermState;
		case (thermState)
			lssl_pkg::LSSL_THERM_RUN: begin
				if (syncPins.overTemp) begin
					next_thermState = lssl_pkg::LSSL_THERM_OFF;
				end
			end
			lssl_pkg::LSSL_THERM_OFF: begin
				// Restart only once cooled by the hysteresis.
				if (syncPins.coolDown && !syncPins.overTemp) begin
					next_thermState = lssl_pkg::LSSL_THERM_RUN;
				end
			end
			default: begin
				next_thermState = lssl_pkg::LSSL_THERM_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			thermState <= lssl_pkg::LSSL_THERM_RUN;
		end else begin
			thermState <= next_thermState;
		end
	end

	assign thermalOff = (thermState == lssl_pkg::LSSL_THERM_OFF);

	// ----------------------------------------
	// Channel gating
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < `LSSL_CHANNELS; ch++) begin : gChannel
			// One sinks when unblanked and cool.
			assign next_sinks[ch] = latchReg[ch] && !syncPins.blank && !thermalOff;
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			channel_sinks <= `LSSL_SINKS_RESET;
		end else begin
			channel_sinks <= next_sinks;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	shift_capture_a: assert property (
		doShift |=> shiftReg == {$past(shiftReg[`LSSL_CHANNELS-2:0]), $past(popBit.data)})
		else $error("Shift register did not capture the buffered bit.");

	shift_idle_a: assert property (
		!doShift |=> $stable(shiftReg))
		else $error("Shift register changed without a rising serial clock.");

	rise_push_a: assert property (
		(clkRise && bitReady && !doShift && !popValid) |=> popValid)
		else $error("Rising serial clock did not reach the buffer.");

	serial_tail_a: assert property (
		doShift |=> serial_out == $past(shiftReg[`LSSL_CHANNELS-2]))
		else $error("Serial output is not the last stage.");

	newest_channel_a: assert property (
		(doShift ##1 syncPins.latchStrobe) |=> latchReg[0] == $past(popBit.data, 2))
		else $error("Newest bit did not land on channel 0.");

	latch_follow_a: assert property (
		syncPins.latchStrobe |=> latchReg == $past(shiftReg))
		else $error("Latch did not follow the shift register.");

	latch_hold_a: assert property (
		!syncPins.latchStrobe |=> $stable(latchReg))
		else $error("Latch changed while the strobe was low.");

	drive_on_a: assert property (
		(!syncPins.blank && !thermalOff) |=> channel_sinks == $past(latchReg))
		else $error("Unblanked channels do not follow the latch.");

	blank_off_a: assert property (
		syncPins.blank |=> channel_sinks == '0 && ($stable(latchReg) || $past(syncPins.latchStrobe)))
		else $error("Blanked channels are not off.");

	strobe_pull_a: assert property (
		(!latchStrobeDriven)[*3] |-> !syncPins.latchStrobe)
		else $error("Undriven strobe did not read low.");

	blank_pull_a: assert property (
		(!blankNDriven)[*3] |-> ##1 channel_sinks == '0)
		else $error("Undriven blanking did not switch channels off.");

	thermal_hold_a: assert property (
		(thermalOff && !syncPins.coolDown) |=> thermalOff ##1 channel_sinks == '0)
		else $error("Thermal shutdown released before cooling.");

	sink_level_a: assert property (
		(!syncPins.blank && !thermalOff && latchReg == '0) |=> channel_sinks == '0)
		else $error("A zero latch bit drove a channel.");

	frame_load_c: cover property (
		doShift ##1 (!doShift)[*1] ##[1:40] strobeFall);

	blank_release_c: cover property (
		syncPins.blank ##1 !syncPins.blank ##1 channel_sinks != '0);

	thermal_cycle_c: cover property (
		!thermalOff ##1 thermalOff ##[1:40] !thermalOff);

	buffer_full_c: cover property (
		!bitReady ##1 bitReady);

endmodule
`default_nettype wire

// ==== tb/lssl_host_model.sv ====
// Host controller model that shifts frames into the LED sink block.
`include "lssl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lssl_host_model (
	// Clock
	input  wire logic clk_sys,
	// Serial and strobe pins
	output logic      serialClk,
	output logic      serialIn,
	output logic      latchStrobe
);
	int gap = 0;

	initial begin
		serialClk   = 1'b0;
		serialIn    = 1'b0;
		latchStrobe = 1'b0;
	end

	// Slow serial clock.
	// Each phase spans several system cycles, far under the rate limit.
	// Once the hold time is over the data line flips, so a late sample shows up.
	task automatic send_bit(input logic b);
		@(posedge clk_sys) serialIn <= b;
		@(posedge clk_sys) serialClk <= 1'b1;
		repeat (3) @(posedge clk_sys);
		serialClk <= 1'b0;
		serialIn  <= ~b;
		repeat (2 + gap) @(posedge clk_sys);
	endtask

	task automatic set_strobe(input logic v);
		@(posedge clk_sys) latchStrobe <= v;
	endtask

	task automatic send_word(input logic [`LSSL_CHANNELS-1:0] w, input logic pulse);
		for (int i = `LSSL_CHANNELS - 1; i >= 0; i--) begin
			send_bit(w[i]);
		end
		if (pulse) begin
			repeat (3) @(posedge clk_sys);
			latchStrobe <= 1'b1;
			repeat (4) @(posedge clk_sys);
			latchStrobe <= 1'b0;
			repeat (6) @(posedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_lssl_top.sv ====
// Self-checking testbench of the LED sink shift and latch block.
`include "lssl_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_lssl_top;
	localparam int N = `LSSL_CHANNELS;
	logic         clk_sys           = 1'b0;
	logic         reset             = 1'b1;
	logic         serialClk;
	logic         serialIn;
	logic         latchStrobe;
	logic         latchStrobeDriven;
	logic         blankN;
	logic         blankNDriven;
	logic         overTemp;
	logic         coolDown;
	logic         shiftHold;
	logic         serialOut;
	logic         bitReady;
	logic         bitDropped;
	logic         thermalOff;
	logic [N-1:0] sinks;
	int           fails             = 0;
	int           n_compared        = 0;
	int           cycles            = 0;

	always #20 clk_sys = ~clk_sys;

	lssl_host_model host (
		.clk_sys     (clk_sys),
		.serialClk   (serialClk),
		.serialIn    (serialIn),
		.latchStrobe (latchStrobe)
	);

	lssl_top dut (
		.clk_sys           (clk_sys),
		.reset             (reset),
		.serialClk         (serialClk),
		.serial_in         (serialIn),
		.serial_out        (serialOut),
		.latch_strobe      (latchStrobe),
		.latchStrobeDriven (latchStrobeDriven),
		.blankN            (blankN),
		.blankNDriven      (blankNDriven),
		.overTemp          (overTemp),
		.coolDown          (coolDown),
		.shiftHold         (shiftHold),
		.bitReady          (bitReady),
		.bitDropped        (bitDropped),
		.channel_sinks     (sinks),
		.thermalOff        (thermalOff)
	);

	// ----------------------------------------
	// Checking and reporting
	// ----------------------------------------
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cmp_word(input logic [N-1:0] got, input logic [N-1:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// Sampling one step after the edge keeps clear of the edge's own updates.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			final_report();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		cmp_word(sinks, 16'h0000, "sinks");
		cmp_bit(serialOut, 1'b0, "serial out");
		cmp_bit(bitReady, 1'b1, "ready");
		cmp_bit(bitDropped, 1'b0, "dropped");
		$display("done reset");
	endtask

	task automatic t_frame();
		host.send_word(16'ha5c3, 1'b1);
		@(posedge clk_sys) blankN <= 1'b0;
		cyc(5);
		cmp_word(sinks, 16'ha5c3, "frame");
		cmp_bit(serialOut, 1'b1, "last stage");
		host.send_bit(1'b0);
		cyc(3);
		cmp_bit(serialOut, 1'b0, "next stage");
		cmp_word(sinks, 16'ha5c3, "held");
		$display("done frame");
	endtask

	task automatic t_latch();
		host.gap = 3;
		host.send_word(16'h3c5a, 1'b0);
		host.gap = 0;
		cyc(2);
		cmp_word(sinks, 16'ha5c3, "strobe low");
		host.set_strobe(1'b1);
		host.send_bit(1'b1);
		cyc(4);
		cmp_word(sinks, 16'h78b5, "transparent");
		host.set_strobe(1'b0);
		$display("done latch");
	endtask

	task automatic t_blank();
		@(posedge clk_sys) blankN <= 1'b1;
		cyc(5);
		cmp_word(sinks, 16'h0000, "blanked");
		@(posedge clk_sys) blankN <= 1'b0;
		cyc(5);
		cmp_word(sinks, 16'h78b5, "unblanked");
		@(posedge clk_sys) blankNDriven <= 1'b0;
		cyc(5);
		cmp_word(sinks, 16'h0000, "blank float");
		@(posedge clk_sys) blankNDriven <= 1'b1;
		@(posedge clk_sys) latchStrobeDriven <= 1'b0;
		host.set_strobe(1'b1);
		host.send_word(16'h0f0f, 1'b0);
		cyc(4);
		cmp_word(sinks, 16'h78b5, "strobe float");
		host.set_strobe(1'b0);
		@(posedge clk_sys) latchStrobeDriven <= 1'b1;
		host.send_word(16'h8001, 1'b1);
		cyc(2);
		cmp_word(sinks, 16'h8001, "edge bits");
		$display("done blank");
	endtask

	task automatic t_thermal();
		@(posedge clk_sys) overTemp <= 1'b1;
		coolDown <= 1'b0;
		cyc(6);
		cmp_bit(thermalOff, 1'b1, "hot");
		cmp_word(sinks, 16'h0000, "hot sinks");
		@(posedge clk_sys) overTemp <= 1'b0;
		cyc(6);
		cmp_bit(thermalOff, 1'b1, "warm");
		@(posedge clk_sys) coolDown <= 1'b1;
		cyc(6);
		cmp_bit(thermalOff, 1'b0, "cooled");
		cmp_word(sinks, 16'h8001, "restored");
		$display("done thermal");
	endtask

	task automatic t_buffer();
		@(posedge clk_sys) shiftHold <= 1'b1;
		host.send_bit(1'b1);
		host.send_bit(1'b1);
		cyc(1);
		cmp_bit(bitReady, 1'b0, "full");
		cmp_bit(bitDropped, 1'b0, "no drop");
		host.send_bit(1'b1);
		cyc(1);
		cmp_bit(bitDropped, 1'b1, "dropped");
		@(posedge clk_sys) shiftHold <= 1'b0;
		cyc(5);
		cmp_bit(bitReady, 1'b1, "drained");
		$display("done buffer");
	endtask

	initial begin
		latchStrobeDriven <= 1'b1;
		blankN            <= 1'b1;
		blankNDriven      <= 1'b1;
		overTemp          <= 1'b0;
		coolDown          <= 1'b1;
		shiftHold         <= 1'b0;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		cyc(3);
		t_reset();
		t_frame();
		t_latch();
		t_blank();
		t_thermal();
		t_buffer();
		final_report();
	end
endmodule
`default_nettype wire
